// ==== logic/mctu_defs.vh ====
// Constants for the memory card transfer unit
`ifndef MCTU_DEFS_VH
`define MCTU_DEFS_VH

// Register indices (byte address is four times the index)
`define MCTU_IDX_PTR      16'hfc7c
`define MCTU_IDX_LEN      16'hfc7d
`define MCTU_IDX_CF       16'hfc7e
`define MCTU_IDX_ST       16'hfc7f
`define MCTU_RST_VAL      16'h0000

// Configuration register fields
`define MCTU_CF_MASK      16'h1cff
`define MCTU_CF_NOCRCSEND 12
`define MCTU_CF_KEEPCRC   11
`define MCTU_CF_WIDE      10
`define MCTU_CF_GO        7
`define MCTU_CF_READ      6
`define MCTU_CF_CMDKIND   5
`define MCTU_CF_NOSTART   4
`define MCTU_CF_NOSTOP    3
`define MCTU_CF_CRC16     2
`define MCTU_CF_CRC7      1
`define MCTU_CF_SEARCH    0

// Clock and status register fields
`define MCTU_ST_DIV_HI    12
`define MCTU_ST_DIV_LO    8
`define MCTU_ST_REPEAT    7
`define MCTU_ST_CMDFLAG   5
`define MCTU_ST_DAT0      4
`define MCTU_ST_ERR_HI    3
`define MCTU_ST_ERR_LO    0
`define MCTU_ERR_STOP     3
`define MCTU_ERR_DCRC     2
`define MCTU_ERR_RCRC     1
`define MCTU_ERR_START    0

// Pattern buffer block select within the pointer
`define MCTU_REP_HI       10
`define MCTU_REP_LO       8

// CRC and timing
`define MCTU_CRC16_POLY   16'h1021
`define MCTU_CRC7_POLY    7'h09
`define MCTU_CRC16_BITS   5'h10
`define MCTU_CRC7_BITS    5'h07
`define MCTU_POLL_LAST    8'hff

`endif

// ==== logic/mctu_card.v ====
// Memory card transfer unit: APB registers, card clock divider and serial engine
//
// Overview of operation
// - Data goes over DAT0 only, or DAT3..0 when wide bus select is set and the kind bit is low.
// - An 11-bit word pointer addresses peripheral memory for sent and received bytes.
// - Exactly the programmed byte count moves per transfer, either direction.
// - Setting the go bit starts a transfer with the current configuration.
// - Direction bit high reads from the card, low writes to it.
// - Kind bit high uses the command line, low the data lines.
// - Omit-start control skips the data start bit.
// - Omit-stop control skips the data stop bit.
// - Suppress-send control keeps the computed CRC off the lines.
// - Keep-accumulator control leaves the CRC running from the previous transfer.
// - Bit 2 enables CRC16, bit 1 CRC7; CRC goes out automatically.
// - Start-bit search gives up after 256 card clocks and flags a timeout.
// - Card clock period is two times (divider plus one), in system clocks.
// - Repeat mode streams a 512-byte buffer picked by pointer bits 10:8.
// - Command start seen during data sets a flag, cleared at each start.
// - Status bit 4 shows the sampled level of DAT0.
// - Data read ending without a valid stop bit flags an error.
// - Failed CRC16 check of read data flags an error.
// - Failed CRC7 check of a command response flags an error.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mctu_defs.vh"

module mctu_card (
  // Clock and reset
  input  wire        CLK,
  input  wire        SRST,
  // APB slave
  input  wire [17:0] PADDR,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Peripheral memory
  output reg  [10:0] MEM_ADDR,
  output reg         MEM_RE,
  output reg         MEM_WE,
  output reg  [15:0] MEM_WDATA,
  input  wire [15:0] MEM_RDATA,
  // Card lines
  output reg         CARD_CLK,
  input  wire        CMD_I,
  output reg         CMD_O,
  output reg         CMD_OE,
  input  wire [3:0]  DAT_I,
  output reg  [3:0]  DAT_O,
  output reg  [3:0]  DAT_OE
);

  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_DATA  = 7'h04;
  localparam [6:0] S_CRC   = 7'h08;
  localparam [6:0] S_STOP  = 7'h10;
  localparam [6:0] S_DONE  = 7'h20;
  localparam [6:0] S_REP   = 7'h40;

  //////////////////////////////////////////////////////////////////////////////
  // CRC steps

  function [15:0] crc16_step;
    input [15:0] c;
    input        b;
    begin
      crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `MCTU_CRC16_POLY : 16'h0000);
    end
  endfunction

  function [6:0] crc7_step;
    input [6:0] c;
    input       b;
    begin
      crc7_step = {c[5:0], 1'b0} ^ ((c[6] ^ b) ? `MCTU_CRC7_POLY : 7'h00);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [4:0]  pin_s1;
  reg  [4:0]  pin_s2;
  reg  [10:0] ptr;
  reg  [15:0] len;
  reg  [15:0] cfg;
  reg  [4:0]  st_div;
  reg         st_rep;
  reg         st_cmdf;
  reg         st_dat0;
  reg  [3:0]  st_err;
  reg  [4:0]  div_cnt;
  reg         fall_en;
  reg         rise_en;
  reg  [6:0]  state;
  reg  [18:0] bits_left;
  reg  [15:0] sh;
  reg  [4:0]  sh_bits;
  reg  [15:0] nxt;
  reg         nxt_ok;
  reg         fetch_pend;
  reg  [15:0] crc16 [0:3];
  reg  [6:0]  crc7;
  reg  [4:0]  crc_cnt;
  reg         crc_bad;
  reg  [7:0]  poll_cnt;
  reg  [7:0]  rep_idx;
  integer     i;

  wire        cmd_in  = pin_s2[4];
  wire [3:0]  dat_in  = pin_s2[3:0];
  wire        go      = cfg[`MCTU_CF_GO];
  wire        rd      = cfg[`MCTU_CF_READ];
  wire        cmdk    = cfg[`MCTU_CF_CMDKIND];
  wire        lanes4  = ~cmdk & cfg[`MCTU_CF_WIDE];
  wire        s_idle  = state[0];
  wire        s_start = state[1];
  wire        s_data  = state[2];
  wire        s_crc   = state[3];
  wire        s_stop  = state[4];
  wire        s_done  = state[5];
  wire        s_rep   = state[6];
  wire        s_run   = s_start | s_data | s_crc | s_stop;

  //////////////////////////////////////////////////////////////////////////////
  // Datapath terms

  wire        tick      = (rd & ~s_rep) ? rise_en : fall_en;
  wire [4:0]  step      = lanes4 ? 5'h04 : 5'h01;
  wire        last      = bits_left <= {14'h0000, step};
  wire [15:0] tx_word   = (sh_bits == 5'h00) ? nxt : sh;
  wire        tx_ready  = (sh_bits != 5'h00) | nxt_ok;
  wire [4:0]  tx_avail  = (sh_bits == 5'h00) ? 5'h10 : sh_bits;
  wire [3:0]  in4       = cmdk ? {cmd_in, 3'b000} : (lanes4 ? dat_in : {dat_in[0], 3'b000});
  wire [15:0] rx_word   = lanes4 ? {sh[11:0], in4} : {sh[14:0], in4[3]};
  wire [4:0]  rx_fill   = sh_bits + step;
  wire [3:0]  cur4      = rd ? in4 : tx_word[15:12];
  wire [3:0]  data_oe   = cmdk ? 4'h0 : (lanes4 ? 4'hf : 4'h1);
  wire        crc_en    = cmdk ? cfg[`MCTU_CF_CRC7] : cfg[`MCTU_CF_CRC16];
  wire        crc_phase = crc_en & (rd | ~cfg[`MCTU_CF_NOCRCSEND]);
  wire        start_ln  = cmdk ? cmd_in : dat_in[0];
  wire        stop_ok   = cmdk ? cmd_in : (lanes4 ? &dat_in : dat_in[0]);
  wire [3:0]  crc_msb   = {crc16[3][15], crc16[2][15], crc16[1][15], crc16[0][15]};
  wire        crc_mis   = cmdk ? (cmd_in ^ crc7[6]) :
                          (lanes4 ? |(dat_in ^ crc_msb) : (dat_in[0] ^ crc_msb[0]));
  wire        fetch_need = ~nxt_ok & ~fetch_pend &
                           (s_rep | (~rd & (s_start | s_data) & (bits_left > {14'h0000, sh_bits})));
  wire [10:0] fetch_addr = s_rep ? {ptr[`MCTU_REP_HI:`MCTU_REP_LO], rep_idx} : ptr;
  wire        op_start  = s_idle & go & ~st_rep;
  wire        op_end    = s_done & tick;

  //////////////////////////////////////////////////////////////////////////////
  // Status events

  wire [3:0]  err_set;
  assign err_set[`MCTU_ERR_START] = s_start & rd & tick & cfg[`MCTU_CF_SEARCH] & start_ln &
                                    (poll_cnt == `MCTU_POLL_LAST);
  assign err_set[`MCTU_ERR_STOP]  = s_stop & rd & tick & ~cmdk & ~stop_ok;
  assign err_set[`MCTU_ERR_DCRC]  = s_crc & rd & tick & ~cmdk & (crc_cnt == 5'h01) &
                                    (crc_bad | crc_mis);
  assign err_set[`MCTU_ERR_RCRC]  = s_crc & rd & tick & cmdk & (crc_cnt == 5'h01) &
                                    (crc_bad | crc_mis);
  wire        cmdf_set  = s_data & ~cmdk & rise_en & ~cmd_in;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire [15:0] idx      = PADDR[17:2];
  wire        word_ok  = PADDR[1:0] == 2'b00;
  wire        hit_ptr  = word_ok & (idx == `MCTU_IDX_PTR);
  wire        hit_len  = word_ok & (idx == `MCTU_IDX_LEN);
  wire        hit_cf   = word_ok & (idx == `MCTU_IDX_CF);
  wire        hit_st   = word_ok & (idx == `MCTU_IDX_ST);
  wire        apb_acc  = PSEL & PENABLE & ~PREADY;
  wire        apb_wr   = PSEL & PENABLE & PREADY & PWRITE;
  wire [15:0] st_word  = {3'b000, st_div, st_rep, 1'b0, st_cmdf, st_dat0, st_err};
  wire [15:0] rd_data  = hit_ptr ? {5'b00000, ptr} : hit_len ? len : hit_cf ? cfg :
                         hit_st ? st_word : 16'h0000;
  wire [3:0]  next_err  = ((apb_wr & hit_st) ? PWDATA[`MCTU_ST_ERR_HI:`MCTU_ST_ERR_LO] : st_err) | err_set;
  wire        next_cmdf = (((apb_wr & hit_st) ? PWDATA[`MCTU_ST_CMDFLAG] : st_cmdf) & ~op_start) | cmdf_set;
  wire [15:0] next_cfg  = (apb_wr & hit_cf) ? (PWDATA[15:0] & `MCTU_CF_MASK) :
                          (op_end ? (cfg & ~(16'h0001 << `MCTU_CF_GO)) : cfg);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and DAT0 level

  always @(posedge CLK) begin
    if (SRST) begin
      pin_s1  <= 5'h1f;
      pin_s2  <= 5'h1f;
      st_dat0 <= 1'b1;
    end else begin
      pin_s1  <= {CMD_I, DAT_I};
      pin_s2  <= pin_s1;
      st_dat0 <= pin_s2[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Card clock divider

  always @(posedge CLK) begin
    if (SRST) begin
      div_cnt  <= 5'h00;
      CARD_CLK <= 1'b0;
      fall_en  <= 1'b0;
      rise_en  <= 1'b0;
    end else begin
      fall_en <= 1'b0;
      rise_en <= 1'b0;
      if (div_cnt >= st_div) begin
        div_cnt  <= 5'h00;
        CARD_CLK <= ~CARD_CLK;
        fall_en  <= CARD_CLK;
        rise_en  <= ~CARD_CLK;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine and registers

  always @(posedge CLK) begin
    if (SRST) begin
      PRDATA     <= 32'h00000000;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
      MEM_ADDR   <= 11'h000;
      MEM_RE     <= 1'b0;
      MEM_WE     <= 1'b0;
      MEM_WDATA  <= 16'h0000;
      CMD_O      <= 1'b1;
      CMD_OE     <= 1'b0;
      DAT_O      <= 4'hf;
      DAT_OE     <= 4'h0;
      ptr        <= 11'h000;
      len        <= `MCTU_RST_VAL;
      cfg        <= `MCTU_RST_VAL;
      st_div     <= 5'h00;
      st_rep     <= 1'b0;
      st_cmdf    <= 1'b0;
      st_err     <= 4'h0;
      state      <= S_IDLE;
      bits_left  <= 19'h00000;
      sh         <= 16'h0000;
      sh_bits    <= 5'h00;
      nxt        <= 16'h0000;
      nxt_ok     <= 1'b0;
      fetch_pend <= 1'b0;
      crc7       <= 7'h00;
      crc_cnt    <= 5'h00;
      crc_bad    <= 1'b0;
      poll_cnt   <= 8'h00;
      rep_idx    <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        crc16[i] <= 16'h0000;
      end
    end else begin
      MEM_RE <= 1'b0;
      MEM_WE <= 1'b0;
      // Prefetch of the next word to send
      if (fetch_pend) begin
        nxt        <= MEM_RDATA;
        nxt_ok     <= 1'b1;
        fetch_pend <= 1'b0;
      end else if (fetch_need) begin
        MEM_RE     <= 1'b1;
        MEM_ADDR   <= fetch_addr;
        fetch_pend <= 1'b1;
        if (s_rep) begin
          rep_idx <= rep_idx + 8'h01;
        end else begin
          ptr <= ptr + 11'h001;
        end
      end
      case (state)
        S_IDLE: begin
          if (st_rep) begin
            state   <= S_REP;
            sh_bits <= 5'h00;
            nxt_ok  <= 1'b0;
            rep_idx <= 8'h00;
          end else if (go) begin
            bits_left <= {len, 3'b000};
            sh_bits   <= 5'h00;
            nxt_ok    <= 1'b0;
            crc_bad   <= 1'b0;
            poll_cnt  <= 8'h00;
            if (!cfg[`MCTU_CF_KEEPCRC]) begin
              crc7 <= 7'h00;
              for (i = 0; i < 4; i = i + 1) begin
                crc16[i] <= 16'h0000;
              end
            end
            state <= cfg[`MCTU_CF_NOSTART] ? S_DATA : S_START;
          end
        end
        S_START: begin
          if (tick && rd) begin
            if (!cfg[`MCTU_CF_SEARCH] || !start_ln) begin
              state <= S_DATA;
            end else if (poll_cnt == `MCTU_POLL_LAST) begin
              state <= S_DONE;
            end else begin
              poll_cnt <= poll_cnt + 8'h01;
            end
          end else if (tick) begin
            CMD_O  <= 1'b0;
            DAT_O  <= 4'h0;
            CMD_OE <= cmdk;
            DAT_OE <= data_oe;
            state  <= S_DATA;
          end
        end
        S_DATA: begin
          if (tick && bits_left == 19'h00000) begin
            state <= crc_phase ? S_CRC : (cfg[`MCTU_CF_NOSTOP] ? S_DONE : S_STOP);
            crc_cnt <= cmdk ? `MCTU_CRC7_BITS : `MCTU_CRC16_BITS;
          end else if (tick && (rd || tx_ready)) begin
            bits_left <= bits_left - {14'h0000, step};
            if (rd) begin
              sh <= rx_word;
              if (rx_fill == 5'h10 || (last && rx_fill == 5'h08)) begin
                MEM_WE    <= 1'b1;
                MEM_ADDR  <= ptr;
                MEM_WDATA <= (rx_fill == 5'h10) ? rx_word : {rx_word[7:0], 8'h00};
                ptr       <= ptr + 11'h001;
                sh_bits   <= 5'h00;
              end else begin
                sh_bits <= rx_fill;
              end
            end else begin
              CMD_O   <= tx_word[15];
              DAT_O   <= lanes4 ? tx_word[15:12] : {3'b111, tx_word[15]};
              CMD_OE  <= cmdk;
              DAT_OE  <= data_oe;
              sh      <= tx_word << step;
              sh_bits <= tx_avail - step;
              if (sh_bits == 5'h00) begin
                nxt_ok <= 1'b0;
              end
            end
            if (lanes4) begin
              for (i = 0; i < 4; i = i + 1) begin
                crc16[i] <= crc16_step(crc16[i], cur4[i]);
              end
            end else begin
              crc16[0] <= crc16_step(crc16[0], cur4[3]);
            end
            crc7 <= crc7_step(crc7, cur4[3]);
            if (last) begin
              state   <= crc_phase ? S_CRC : (cfg[`MCTU_CF_NOSTOP] ? S_DONE : S_STOP);
              crc_cnt <= cmdk ? `MCTU_CRC7_BITS : `MCTU_CRC16_BITS;
            end
          end
        end
        S_CRC: begin
          if (tick) begin
            if (rd) begin
              crc_bad <= crc_bad | crc_mis;
            end else begin
              CMD_O <= crc7[6];
              DAT_O <= lanes4 ? crc_msb : {3'b111, crc_msb[0]};
            end
            crc7 <= {crc7[5:0], 1'b0};
            for (i = 0; i < 4; i = i + 1) begin
              crc16[i] <= {crc16[i][14:0], 1'b0};
            end
            crc_cnt <= crc_cnt - 5'h01;
            if (crc_cnt == 5'h01) begin
              state <= cfg[`MCTU_CF_NOSTOP] ? S_DONE : S_STOP;
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            CMD_O <= 1'b1;
            DAT_O <= 4'hf;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          if (tick) begin
            CMD_OE <= 1'b0;
            DAT_OE <= 4'h0;
            state  <= S_IDLE;
          end
        end
        S_REP: begin
          if (tick && !st_rep) begin
            state <= S_DONE;
          end else if (tick && tx_ready) begin
            DAT_O   <= lanes4 ? tx_word[15:12] : {3'b111, tx_word[15]};
            DAT_OE  <= lanes4 ? 4'hf : 4'h1;
            sh      <= tx_word << step;
            sh_bits <= tx_avail - step;
            if (sh_bits == 5'h00) begin
              nxt_ok <= 1'b0;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // Software clearing go cancels a running transfer
      if (s_run && !go) begin
        state <= S_DONE;
      end
      // APB slave, one wait state
      PREADY  <= apb_acc;
      PSLVERR <= apb_acc & ~(hit_ptr | hit_len | hit_cf | hit_st);
      if (apb_acc) begin
        PRDATA <= {16'h0000, rd_data};
      end
      if (apb_wr && hit_ptr) begin
        ptr <= PWDATA[10:0];
      end
      if (apb_wr && hit_len) begin
        len <= PWDATA[15:0];
      end
      if (apb_wr && hit_st) begin
        st_div <= PWDATA[`MCTU_ST_DIV_HI:`MCTU_ST_DIV_LO];
        st_rep <= PWDATA[`MCTU_ST_REPEAT];
      end
      cfg     <= next_cfg;
      st_err  <= next_err;
      st_cmdf <= next_cmdf;
    end
  end

endmodule
`default_nettype wire

// ==== verification/mctu_card_properties.sv ====
// Concurrent checks on the ports of the memory card transfer unit
`timescale 1ns/1ps
`default_nettype none
module mctu_card_props (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Register bus
  input wire logic [17:0] PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Memory and card lines
  input wire logic        MEM_RE,
  input wire logic        MEM_WE,
  input wire logic        CARD_CLK,
  input wire logic        CMD_O,
  input wire logic        CMD_OE,
  input wire logic [3:0]  DAT_O
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  //////////////////////////////////////////////////////////////////////////////
  // Card clock half period tracking
  logic [7:0] cnt;
  logic [4:0] div;
  logic       last;
  logic       arm;
  always @(posedge CLK) begin
    if (SRST) begin
      cnt  <= 8'h00;
      div  <= 5'h00;
      last <= 1'b0;
      arm  <= 1'b0;
    end else begin
      last <= CARD_CLK;
      cnt  <= (CARD_CLK != last) ? 8'h00 : cnt + 8'h01;
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 18'h3f1fc) begin
        div <= PWDATA[12:8];
        arm <= 1'b0;
      end else if (CARD_CLK != last) begin
        arm <= 1'b1;
      end
    end
  end
  sequence s_clk_high2;
    CARD_CLK ##1 CARD_CLK;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_PREADY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access not answered after one wait state");
  AST_PREADY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error response without ready");
  AST_RDATA_HIGH_ZERO: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_MEM_ONE_ACCESS: assert property (!(MEM_RE && MEM_WE))
    else $error("memory read and write together");
  AST_MEM_RE_PULSE: assert property (MEM_RE |=> !MEM_RE)
    else $error("memory read strobe too long");
  AST_CARD_CLK_HALF: assert property (arm && CARD_CLK != last |-> cnt == {3'b000, div})
    else $error("card clock half period wrong");
  AST_CMD_START_LOW: assert property ($rose(CMD_OE) |-> CMD_O == 1'b0)
    else $error("command frame without start bit");
  AST_CMD_STOP_HIGH: assert property ($fell(CMD_OE) |-> $past(CMD_O) == 1'b1)
    else $error("command frame without stop bit");
  AST_LINES_HOLD: assert property (s_clk_high2 |-> $stable(CMD_O) && $stable(DAT_O))
    else $error("card lines change while card clock high");
endmodule

bind mctu_card mctu_card_props u_mctu_card_props (
  .CLK(CLK), .SRST(SRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_RE(MEM_RE),
  .MEM_WE(MEM_WE), .CARD_CLK(CARD_CLK), .CMD_O(CMD_O), .CMD_OE(CMD_OE), .DAT_O(DAT_O)
);
`default_nettype wire

// ==== verification/mctu_card_peer.sv ====
// Behavioural memory card on the command and data lines
`timescale 1ns/1ps
`default_nettype none
module mctu_card_peer (
  // Card lines
  input  wire logic       card_clk,
  input  wire logic       cmd_o,
  input  wire logic       cmd_oe,
  input  wire logic [3:0] dat_o,
  input  wire logic [3:0] dat_oe,
  output wire logic       cmd_i,
  output wire logic [3:0] dat_i,
  // Frame control
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       send_stop,
  input  wire logic       busy
);
  logic [9:0] sh    = 10'h3ff;
  logic [3:0] left  = 4'h0;
  logic       drv   = 1'b0;
  logic       bit_o = 1'b1;
  logic       sent  = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // Start bit, byte MSB first, stop bit on data line 0
  always @(negedge card_clk) begin
    if (left != 4'h0) begin
      drv   <= 1'b1;
      bit_o <= sh[9];
      sh    <= {sh[8:0], 1'b1};
      left  <= left - 4'h1;
    end else if (send && !sent) begin
      sh   <= {1'b0, send_byte, send_stop};
      left <= 4'ha;
      sent <= 1'b1;
      drv  <= 1'b0;
    end else begin
      drv  <= 1'b0;
      sent <= sent & send;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Pulled-up lines, busy holds data line 0 low
  assign cmd_i      = cmd_oe ? cmd_o : 1'b1;
  assign dat_i[0]   = dat_oe[0] ? dat_o[0] : (drv ? bit_o : !busy);
  assign dat_i[3:1] = (dat_oe[3:1] & dat_o[3:1]) | ~dat_oe[3:1];
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Directed register and card transfer tests for the memory card transfer unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [17:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rv, cv, bv;
  logic [10:0] MEM_ADDR, wa;
  logic        MEM_RE, MEM_WE, CARD_CLK, CMD_I, CMD_O, CMD_OE, re;
  logic [15:0] MEM_WDATA, MEM_RDATA, wd;
  logic [3:0]  DAT_I, DAT_O, DAT_OE;
  logic        send, send_stop, busy;
  logic [7:0]  send_byte;
  logic [15:0] mem [0:2047];
  logic [63:0] dv;
  int          cn, dn, mismatches, n_tests;
  localparam logic [17:0] A_PTR = 18'h3f1f0;
  localparam logic [17:0] A_LEN = 18'h3f1f4;
  localparam logic [17:0] A_CF  = 18'h3f1f8;
  localparam logic [17:0] A_ST  = 18'h3f1fc;
  //////////////////////////////////////////////////////////////////////////////
  // Design, card and memory
  mctu_card u_mctu_card (
    .CLK(CLK), .SRST(SRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_ADDR(MEM_ADDR),
    .MEM_RE(MEM_RE), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .CARD_CLK(CARD_CLK), .CMD_I(CMD_I), .CMD_O(CMD_O), .CMD_OE(CMD_OE), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .DAT_OE(DAT_OE));
  mctu_card_peer u_mctu_card_peer (
    .card_clk(CARD_CLK), .cmd_o(CMD_O), .cmd_oe(CMD_OE), .dat_o(DAT_O), .dat_oe(DAT_OE),
    .cmd_i(CMD_I), .dat_i(DAT_I), .send(send), .send_byte(send_byte), .send_stop(send_stop),
    .busy(busy));
  assign MEM_RDATA = mem[MEM_ADDR];
  always @(posedge CLK) begin
    if (MEM_WE === 1'b1) begin
      wa <= MEM_ADDR;
      wd <= MEM_WDATA;
    end
  end
  always @(posedge CARD_CLK) begin
    if (CMD_OE === 1'b1) begin
      cv <= {cv[30:0], CMD_O};
      cn <= cn + 1;
    end
    if (DAT_OE !== 4'h0) begin
      dv <= {dv[59:0], DAT_O};
      bv <= {bv[30:0], DAT_O[0]};
      dn <= dn + 1;
    end
  end
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d);
    int n;
    n = 0;
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= {16'h0000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    re = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
    if (n >= 20) begin
      mismatches++;
      stop_test;
    end
  endtask
  task automatic rd(input string nm, input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 16'h0000);
    chk(nm, e, rv);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, A_CF, 16'h0000);
      n++;
    end while (rv[7] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      mismatches++;
      stop_test;
    end
  endtask
  function automatic logic [6:0] crc7(input logic [7:0] b);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 7; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((b[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {SRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 18'h0, 32'h0};
    {send, send_stop, busy, send_byte, mismatches, n_tests, cn, dn} = '0;
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    rd("ptr", A_PTR, 32'h0);
    rd("len", A_LEN, 32'h0);
    rd("cf", A_CF, 32'h0);
    rd("st", A_ST, 32'h10);
    apb(1'b0, 18'h3f200, 16'h0000);
    chk("unmapped", 32'h1, {31'h0, re});
    apb(1'b1, A_PTR, 16'hffff);
    rd("ptr width", A_PTR, 32'h7ff);
    apb(1'b1, A_CF, 16'hff7f);
    rd("cf fields", A_CF, 32'h1c7f);
    apb(1'b1, A_ST, 16'h0100);
    mem[11'h010] = 16'h4d00;
    apb(1'b1, A_PTR, 16'h0010);
    apb(1'b1, A_LEN, 16'h0001);
    cn = 0;
    apb(1'b1, A_CF, 16'h00a2);
    wait_idle;
    chk("cmd frame", {15'h0, 1'b0, 8'h4d, crc7(8'h4d), 1'b1}, {15'h0, cv[16:0]});
    chk("cmd count", 32'd17, cn);
    rd("ptr advance", A_PTR, 32'h11);
    mem[11'h020] = 16'h5ac3;
    apb(1'b1, A_PTR, 16'h0020);
    apb(1'b1, A_LEN, 16'h0002);
    dn = 0;
    apb(1'b1, A_CF, 16'h0488);
    wait_idle;
    chk("wide lanes", 32'h0005ac3, {12'h0, dv[19:0]});
    chk("wide count", 32'd5, dn);
    mem[11'h030] = 16'h9600;
    apb(1'b1, A_PTR, 16'h0030);
    apb(1'b1, A_LEN, 16'h0001);
    dn = 0;
    apb(1'b1, A_CF, 16'h1094);
    wait_idle;
    chk("narrow bits", 32'h12d, {23'h0, bv[8:0]});
    chk("narrow count", 32'd9, dn);
    apb(1'b1, A_PTR, 16'h0040);
    apb(1'b1, A_CF, 16'h00c1);
    wait_idle;
    rd("timeout", A_ST, 32'h0111);
    apb(1'b1, A_ST, 16'h0100);
    send_byte <= 8'hc5;
    apb(1'b1, A_CF, 16'h00c1);
    send <= 1'b1;
    wait_idle;
    send <= 1'b0;
    chk("store addr", 32'h40, {21'h0, wa});
    chk("store data", 32'hc500, {16'h0, wd});
    rd("stop err", A_ST, 32'h0118);
    apb(1'b1, A_ST, 16'h0100);
    send_stop <= 1'b1;
    apb(1'b1, A_CF, 16'h00c5);
    send <= 1'b1;
    wait_idle;
    send <= 1'b0;
    rd("crc err", A_ST, 32'h0114);
    chk("store addr2", 32'h41, {21'h0, wa});
    busy <= 1'b1;
    apb(1'b0, A_ST, 16'h0000);
    rd("line low", A_ST, 32'h0104);
    for (int k = 0; k < 256; k++) mem[11'h100 + k] = 16'h5555;
    apb(1'b1, A_CF, 16'h0400);
    apb(1'b1, A_PTR, 16'h0100);
    apb(1'b1, A_ST, 16'h0180);
    repeat (80) @(posedge CLK);
    apb(1'b1, A_ST, 16'h0100);
    repeat (20) @(posedge CLK);
    chk("repeat lanes", 32'h5555, {16'h0, dv[15:0]});
    stop_test;
  end
endmodule
`default_nettype wire
